// [src/slt_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the line sequencer.
// Assumes: A 32-bit APB register file with one aligned word per register.
// Notes: Included by its bare name wherever the constants are needed.
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH

// Register byte offsets.
`define SLT_A_CTRL 8'h00
`define SLT_A_LINE 8'h04
`define SLT_A_PWM 8'h08
`define SLT_A_LAMP_R 8'h0C
`define SLT_A_LAMP_G 8'h10
`define SLT_A_LAMP_B 8'h14
`define SLT_A_XFER 8'h18
`define SLT_A_PIX 8'h1C
`define SLT_A_LRATE 8'h20
`define SLT_A_STAT 8'h24

// Control word field positions.
`define SLT_C_MODE 0
`define SLT_C_SRST 2
`define SLT_C_STBY 3
`define SLT_C_DSAMP 4
`define SLT_C_FOB 5
`define SLT_C_TRM 6
`define SLT_C_AFE 8
`define SLT_C_GSEL 10
`define SLT_C_GO 12
`define SLT_C_STOP 13

// Pixel word field positions (three 8-phase masks, then two sample phases).
`define SLT_P_AUXA 8
`define SLT_P_AUXB 16
`define SLT_P_REF 24
`define SLT_P_SIG 27

// Reset values.
`define SLT_RST_CTRL 32'h0000_0010
`define SLT_RST_LINE 32'h0010_0100
`define SLT_RST_XFER 32'h0000_0004
`define SLT_RST_PIX 32'h2A00_0001

// Timing: a pixel is eight master clocks, a sensor phase period likewise.
`define SLT_SUB_LAST 3'h7
`define SLT_PHI_HIGH 3'h4
`define SLT_PHI_PERIOD 16'h0008
`define SLT_CIS2_START 16'h0006
`define SLT_CIS2_END 16'h000E
`define SLT_LC_MAX 16'hFFFF

`endif

// [src/slt_pkg.sv]
// Purpose: Types shared by the line sequencer.
// Assumes: Constants live in slt_params.svh.
// Notes: The whole module state is one packed struct.
package slt_pkg;

    // Illumination modes.
    typedef enum logic [1:0] {ILL_OFF, ILL_WHITE, ILL_COLOUR, ILL_GRAY} slt_illum_e;

    // Converter multiplexer sequencing modes.
    typedef enum logic [1:0] {AFE_PIXEL, AFE_LINE, AFE_GRAY, AFE_MONO} slt_afe_e;

    // Transfer pulse timing modes.
    typedef enum logic [1:0] {TRM_NORMAL, TRM_CIS_ONE, TRM_CIS_CENTRE, TRM_SPARE} slt_trm_e;

    // Complete register and sequencer state.
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] line;
        logic [31:0] xfer;
        logic [31:0] pix;
        logic [11:0] duty;
        logic [2:0][31:0] lamp_pos;
        logic [8:0] lrate;
        logic [15:0] hcnt;
        logic [15:0] lc;
        logic [2:0] sub;
        logic [1:0] col;
        logic [1:0] prev_col;
        logic [11:0] pwm;
        logic [2:0] lamp;
        logic [5:0] skip;
        logic sreset;
        logic aux_a;
        logic aux_b;
        logic xfer1;
        logic xfer2;
        logic phi1;
        logic clamp;
        logic sref;
        logic ssig;
        logic int_ref;
        logic scan;
        logic pend;
        logic [1:0] mux;
        logic [1:0] coef;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } slt_state_s;

endpackage : slt_pkg

// [src/slt_seq.sv]
// Purpose: Line-synchronous lamp, sensor clock and converter multiplexer sequencer.
// Assumes: One 20 MHz master clock; registers reached over APB with zero wait states.
// Notes: All outputs are flip-flops; the sequencer stops while soft reset or standby is set.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "slt_params.svh"

module slt_seq (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_lamp_r,
    output logic o_lamp_g,
    output logic o_lamp_b,
    output logic o_sensor_reset_pulse,
    output logic o_aux_pixel_pulse_a,
    output logic o_aux_pixel_pulse_b,
    output logic o_transfer_pulse_first,
    output logic o_transfer_pulse_second,
    output logic o_phase1,
    output logic o_clamp,
    output logic o_sample_ref,
    output logic o_sample_sig,
    output logic o_int_ref,
    output logic [1:0] o_mux_sel,
    output logic [1:0] o_coef_sel,
    output logic o_scanning
);

    slt_pkg::slt_state_s q; // Registered state.
    slt_pkg::slt_state_s d; // Next state.

    // Next-state logic for the register file, timebase, lamps and sensor clocks.
    always_comb begin
        logic halt;
        logic lstart;
        logic fob;
        logic dsamp;
        logic en;
        logic [15:0] le;
        logic [15:0] obe;
        logic [15:0] st;
        logic [15:0] nend;
        logic [15:0] xend;
        logic [15:0] gb;
        logic [1:0] cnt;
        slt_pkg::slt_illum_e ill;
        slt_pkg::slt_afe_e afe;
        slt_pkg::slt_trm_e trm;
        d = q;
        halt = q.ctrl[`SLT_C_SRST] | q.ctrl[`SLT_C_STBY];
        lstart = 1'b0;
        fob = q.ctrl[`SLT_C_FOB];
        dsamp = q.ctrl[`SLT_C_DSAMP];
        en = 1'b0;
        le = q.line[15:0];
        obe = q.line[31:16];
        gb = {8'h00, q.xfer[15:8]};
        st = 16'h0000;
        nend = 16'h0000;
        xend = 16'h0000;
        cnt = 2'h0;
        ill = slt_pkg::slt_illum_e'(q.ctrl[`SLT_C_MODE +: 2]);
        afe = slt_pkg::slt_afe_e'(q.ctrl[`SLT_C_AFE +: 2]);
        trm = slt_pkg::slt_trm_e'(q.ctrl[`SLT_C_TRM +: 2]);
        // Single-sensor colour always rotates the lamps one colour per line.
        if (afe == slt_pkg::AFE_MONO) begin
            ill = slt_pkg::ILL_COLOUR;
        end

        // APB: pready rises in the first access cycle, so every access takes two cycles.
        d.rdy = i_psel & ~i_penable;
        d.err = 1'b0;
        d.rdata = 32'h0000_0000;
        if (i_psel & ~i_penable) begin
            if (i_paddr == `SLT_A_CTRL) begin
                d.rdata = q.ctrl;
            end else if (i_paddr == `SLT_A_LINE) begin
                d.rdata = q.line;
            end else if (i_paddr == `SLT_A_PWM) begin
                d.rdata = {20'h0_0000, q.duty};
            end else if (i_paddr == `SLT_A_LAMP_R) begin
                d.rdata = q.lamp_pos[0];
            end else if (i_paddr == `SLT_A_LAMP_G) begin
                d.rdata = q.lamp_pos[1];
            end else if (i_paddr == `SLT_A_LAMP_B) begin
                d.rdata = q.lamp_pos[2];
            end else if (i_paddr == `SLT_A_XFER) begin
                d.rdata = q.xfer;
            end else if (i_paddr == `SLT_A_PIX) begin
                d.rdata = q.pix;
            end else if (i_paddr == `SLT_A_LRATE) begin
                d.rdata = {23'h00_0000, q.lrate};
            end else if (i_paddr == `SLT_A_STAT) begin
                d.rdata = {10'h000, q.lamp, q.scan, q.col, q.hcnt};
            end else begin
                // Unmapped addresses answer with an error and zero data.
                d.err = 1'b1;
            end
        end

        // Horizontal timebase; it never stops except in soft reset or standby.
        if (halt) begin
            d.hcnt = 16'h0000;
            d.sub = 3'h0;
            d.lc = 16'h0000;
            d.col = 2'h0;
            d.prev_col = 2'h0;
            d.skip = 6'h00;
            d.pwm = 12'h000;
        end else begin
            d.sub = q.sub + 3'h1;
            d.pwm = q.pwm + 12'h001;
            if (q.lc != `SLT_LC_MAX) begin
                d.lc = q.lc + 16'h0001;
            end
            if (q.sub == `SLT_SUB_LAST) begin
                d.hcnt = q.hcnt + 16'h0001;
            end
            // A line ends on the last phase of the pixel at the line end value.
            lstart = (q.sub == `SLT_SUB_LAST) && (q.hcnt >= le);
            if (lstart) begin
                d.hcnt = 16'h0000;
                d.lc = 16'h0000;
                d.prev_col = q.col;
                d.col = (q.col == 2'h2) ? 2'h0 : q.col + 2'h1;
                // Each colour fires on one line in every skip-plus-one.
                for (int i = 0; i < 3; i++) begin
                    cnt = q.skip[2 * i +: 2];
                    d.skip[2 * i +: 2] = (cnt == 2'h0) ? q.lrate[2 * i +: 2] : cnt - 2'h1;
                end
            end
        end

        // A scan begins only at a line start, and in colour rotation only before red.
        if (q.pend && lstart && (ill != slt_pkg::ILL_COLOUR || q.col == 2'h2)) begin
            d.scan = 1'b1;
            d.pend = 1'b0;
        end
        if (q.ctrl[`SLT_C_SRST]) begin
            d.scan = 1'b0;
            d.pend = 1'b0;
        end

        // Register writes take effect at the access edge with pready high.
        if (i_psel & i_penable & i_pwrite & q.rdy) begin
            if (i_paddr == `SLT_A_CTRL) begin
                d.ctrl = i_pwdata;
                d.ctrl[`SLT_C_GO] = 1'b0;
                d.ctrl[`SLT_C_STOP] = 1'b0;
                if (i_pwdata[`SLT_C_STOP]) begin
                    d.scan = 1'b0;
                    d.pend = 1'b0;
                end else if (i_pwdata[`SLT_C_GO]) begin
                    d.pend = 1'b1;
                end
            end else if (i_paddr == `SLT_A_LINE) begin
                d.line = i_pwdata;
            end else if (i_paddr == `SLT_A_PWM) begin
                d.duty = i_pwdata[11:0];
            end else if (i_paddr == `SLT_A_LAMP_R) begin
                d.lamp_pos[0] = i_pwdata;
            end else if (i_paddr == `SLT_A_LAMP_G) begin
                d.lamp_pos[1] = i_pwdata;
            end else if (i_paddr == `SLT_A_LAMP_B) begin
                d.lamp_pos[2] = i_pwdata;
            end else if (i_paddr == `SLT_A_XFER) begin
                d.xfer = i_pwdata;
            end else if (i_paddr == `SLT_A_PIX) begin
                d.pix = i_pwdata;
            end else if (i_paddr == `SLT_A_LRATE) begin
                d.lrate = i_pwdata[8:0];
            end
        end

        // Lamps: a hit on the off position wins over a hit on the on position.
        for (int i = 0; i < 3; i++) begin
            case (ill)
                slt_pkg::ILL_OFF: en = 1'b0;
                slt_pkg::ILL_WHITE: en = (i != 1);
                slt_pkg::ILL_COLOUR: en = (q.col == i[1:0]);
                default: en = 1'b1;
            endcase
            if (!en || halt) begin
                d.lamp[i] = 1'b0;
            end else if (q.hcnt == q.lamp_pos[i][31:16]) begin
                d.lamp[i] = 1'b0;
            end else if (q.hcnt == q.lamp_pos[i][15:0]) begin
                d.lamp[i] = 1'b1;
            end
        end
        // The green lamp carries the brightness PWM in white-light mode.
        if (ill == slt_pkg::ILL_WHITE && !halt) begin
            d.lamp[1] = (q.pwm < q.duty);
        end

        // Transfer window in master clocks since line start.
        case (trm)
            slt_pkg::TRM_CIS_ONE: begin
                st = 16'h0000;
                nend = `SLT_PHI_PERIOD;
            end
            slt_pkg::TRM_CIS_CENTRE: begin
                st = `SLT_CIS2_START;
                nend = `SLT_CIS2_END;
            end
            default: begin
                st = gb;
                nend = gb + {8'h00, q.xfer[7:0]};
            end
        endcase
        // Fake black stretches the first transfer by one clock around its reset pulse.
        xend = fob ? nend + 16'h0001 : nend;

        // Sensor phase: suppressed around the transfer only in normal timing mode with a guardband set.
        d.phi1 = (q.sub < `SLT_PHI_HIGH) &&
                 !(trm == slt_pkg::TRM_NORMAL && gb != 16'h0000 && q.lc < nend + gb);

        // Pixel-rate pulses come from eight-phase masks.
        d.sreset = q.pix[q.sub];
        d.aux_a = q.pix[`SLT_P_AUXA + q.sub];
        d.aux_b = q.pix[`SLT_P_AUXB + q.sub];
        if (fob && q.hcnt < obe) begin
            d.sreset = (q.lc == nend) || (q.lc >= nend + 16'h0002);
        end

        if (afe == slt_pkg::AFE_LINE) begin
            // One transfer per colour, inside or outside phase high, skippable.
            d.xfer1 = (q.lc < `SLT_PHI_PERIOD) && (q.lc[2] == q.lrate[6]) &&
                      (q.skip[1:0] == q.lrate[1:0]);
            d.xfer2 = (q.lc < `SLT_PHI_PERIOD) && (q.lc[2] == q.lrate[7]) &&
                      (q.skip[3:2] == q.lrate[3:2]);
            d.aux_b = (q.lc < `SLT_PHI_PERIOD) && (q.lc[2] == q.lrate[8]) &&
                      (q.skip[5:4] == q.lrate[5:4]);
        end else begin
            d.xfer1 = (q.lc >= st) && (q.lc < xend);
            d.xfer2 = (q.lc >= st) && (q.lc < nend);
        end

        // Pixel pulses end at line end; the clamp ends with the optical black pixels.
        if (q.hcnt >= le) begin
            d.sreset = 1'b0;
            d.aux_a = 1'b0;
            d.aux_b = 1'b0;
        end
        d.clamp = (q.hcnt < obe);

        // Sample strobes; without double sampling the reference is internal.
        d.sref = dsamp && (q.sub == q.pix[`SLT_P_REF +: 3]);
        d.ssig = (q.sub == q.pix[`SLT_P_SIG +: 3]);
        d.int_ref = !dsamp;

        // Converter multiplexer and coefficient selection.
        case (afe)
            slt_pkg::AFE_PIXEL: begin
                if (lstart) begin
                    d.mux = 2'h0;
                end else if (q.sub == `SLT_SUB_LAST) begin
                    d.mux = (q.mux == 2'h2) ? 2'h0 : q.mux + 2'h1;
                end
                d.coef = d.mux;
            end
            slt_pkg::AFE_LINE: begin
                d.mux = d.col;
                d.coef = d.col;
            end
            slt_pkg::AFE_GRAY: begin
                d.mux = q.ctrl[`SLT_C_GSEL +: 2];
                d.coef = q.ctrl[`SLT_C_GSEL +: 2];
            end
            default: begin
                // The readout lags the exposure by one line.
                d.mux = 2'h2;
                d.coef = d.prev_col;
            end
        endcase

        // Nothing clocks the sensor while held.
        if (halt) begin
            d.sreset = 1'b0;
            d.aux_a = 1'b0;
            d.aux_b = 1'b0;
            d.xfer1 = 1'b0;
            d.xfer2 = 1'b0;
            d.phi1 = 1'b0;
            d.clamp = 1'b0;
            d.sref = 1'b0;
            d.ssig = 1'b0;
            d.mux = 2'h0;
            d.coef = 2'h0;
        end
    end

    // State register; reset loads constants only.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
            q.ctrl <= `SLT_RST_CTRL;
            q.line <= `SLT_RST_LINE;
            q.xfer <= `SLT_RST_XFER;
            q.pix <= `SLT_RST_PIX;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign o_prdata = q.rdata;
    assign o_pready = q.rdy;
    assign o_pslverr = q.err;
    assign o_lamp_r = q.lamp[0];
    assign o_lamp_g = q.lamp[1];
    assign o_lamp_b = q.lamp[2];
    assign o_sensor_reset_pulse = q.sreset;
    assign o_aux_pixel_pulse_a = q.aux_a;
    assign o_aux_pixel_pulse_b = q.aux_b;
    assign o_transfer_pulse_first = q.xfer1;
    assign o_transfer_pulse_second = q.xfer2;
    assign o_phase1 = q.phi1;
    assign o_clamp = q.clamp;
    assign o_sample_ref = q.sref;
    assign o_sample_sig = q.ssig;
    assign o_int_ref = q.int_ref;
    assign o_mux_sel = q.mux;
    assign o_coef_sel = q.coef;
    assign o_scanning = q.scan;

    // Checks on the sequencer outputs.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    chk_lamps_mode_off: assert property (
        (q.ctrl[1:0] == 2'h0 && q.ctrl[9:8] != 2'h3) |=> !o_lamp_r && !o_lamp_g && !o_lamp_b)
        else $error("Lamp lit in illumination mode 0.");
    chk_pwm_green_duty: assert property (
        (q.ctrl[1:0] == 2'h1 && q.ctrl[9:8] != 2'h3 && !q.ctrl[2] && !q.ctrl[3])
        |=> (o_lamp_g == ($past(q.pwm) < $past(q.duty))))
        else $error("Green PWM does not follow the duty setting.");
    chk_lamp_off_hit: assert property (
        (q.ctrl[1:0] != 2'h0 && q.ctrl[1:0] != 2'h1 && q.hcnt == q.lamp_pos[0][31:16])
        |=> !o_lamp_r)
        else $error("Red lamp still on at its off position.");
    chk_colour_one_lamp: assert property (
        (q.ctrl[1:0] == 2'h2) |=> $onehot0({o_lamp_r, o_lamp_g, o_lamp_b}))
        else $error("More than one lamp lit in colour rotation.");
    chk_line_end_quiet: assert property (
        (q.hcnt >= q.line[15:0]) |=> !o_sensor_reset_pulse && !o_aux_pixel_pulse_a)
        else $error("Pixel pulse active at line end.");
    chk_xfer_same_width: assert property (
        (q.ctrl[9:8] != 2'h1 && !q.ctrl[5]) |=> (o_transfer_pulse_first == o_transfer_pulse_second))
        else $error("Transfer pulses differ in width.");
    chk_cis_one_len: assert property (
        ($rose(o_transfer_pulse_first) && q.ctrl[7:6] == 2'h1 && q.ctrl[9:8] != 2'h1 &&
         !q.ctrl[5] && !q.ctrl[2] && !q.ctrl[3] && $stable(q.ctrl))
        |-> o_transfer_pulse_first [*8] ##1 !o_transfer_pulse_first)
        else $error("Timing mode 1 transfer is not one phase period.");
    chk_halt_no_clock: assert property (
        (q.ctrl[2] || q.ctrl[3]) |=> !o_sensor_reset_pulse && !o_transfer_pulse_first && !o_phase1)
        else $error("Sensor clocked during reset or standby.");
    chk_scan_at_line: assert property (
        $rose(o_scanning) |-> (q.hcnt == 16'h0000 && q.lc == 16'h0000))
        else $error("Scan started away from a line start.");
    chk_dsamp_off_ref: assert property (
        !q.ctrl[4] |=> !o_sample_ref && o_int_ref)
        else $error("Reference sampled with double sampling off.");
    chk_mono_blue_in: assert property (
        (q.ctrl[9:8] == 2'h3 && !q.ctrl[2] && !q.ctrl[3]) |=> (o_mux_sel == 2'h2))
        else $error("Mono colour mode not reading the blue input.");

endmodule : slt_seq

// [test/slt_sensor_model.sv]
// Purpose: Sensor and lamp load model that tallies what the sequencer drives.
// Assumes: Sensor side outputs are sampled on the master clock.
// Notes: i_clr restarts all tallies, so the bench can measure exact windows.
`timescale 1ns/1ps
module slt_sensor_model (
    input wire logic i_mclk,
    input wire logic i_clr,
    input wire logic [2:0] i_lamp,
    input wire logic i_tr1,
    input wire logic i_tr2,
    input wire logic i_aux_b,
    input wire logic i_phase1,
    input wire logic [1:0] i_mux,
    input wire logic [1:0] i_coef,
    input wire logic i_rs,
    input wire logic i_clamp,
    input wire logic i_ssig,
    input wire logic i_sref
);
    // Tallies: 0-2 lamp clocks, 3-5 pulse starts, 6 phase starts, 7-9 channel clocks,
    // 10 blue weights, 11 lamp overlap, 12-13 last widths, 14-15 edges off phase,
    // 16 reset pulse clocks, 17 clamp clocks, 18-19 signal and reference strobes.
    logic [31:0] cnt [20];
    logic [7:0] run1, run2; // Running transfer pulse widths.
    logic tr1_q, tr2_q, aux_q, ph_q; // Last samples, used to find edges.

    // The sensor only listens, so this is a passive tally that never drives back.
    always @(posedge i_mclk) begin
        if (i_clr) begin
            for (int k = 0; k < 20; k++) begin
                cnt[k] <= 32'h0;
            end
        end else begin
            for (int k = 0; k < 3; k++) begin
                cnt[k] <= cnt[k] + 32'(i_lamp[k]);
                cnt[7 + k] <= cnt[7 + k] + 32'(i_mux == 2'(k));
            end
            cnt[3] <= cnt[3] + 32'(i_tr1 & ~tr1_q);
            cnt[4] <= cnt[4] + 32'(i_tr2 & ~tr2_q);
            cnt[5] <= cnt[5] + 32'(i_aux_b & ~aux_q);
            cnt[6] <= cnt[6] + 32'(i_phase1 & ~ph_q);
            cnt[10] <= cnt[10] + 32'(i_coef == 2'h2);
            cnt[16] <= cnt[16] + 32'(i_rs);
            cnt[17] <= cnt[17] + 32'(i_clamp);
            cnt[18] <= cnt[18] + 32'(i_ssig);
            cnt[19] <= cnt[19] + 32'(i_sref);
            cnt[11] <= cnt[11] + 32'((i_lamp & (i_lamp - 3'h1)) != 3'h0);
            cnt[14] <= cnt[14] + 32'((i_tr1 != tr1_q) && (i_phase1 != i_tr1));
            cnt[15] <= cnt[15] + 32'((i_tr2 != tr2_q) && (i_phase1 == i_tr2));
            if (tr1_q && !i_tr1) begin
                cnt[12] <= 32'(run1);
            end
            if (tr2_q && !i_tr2) begin
                cnt[13] <= 32'(run2);
            end
        end
        run1 <= i_tr1 ? run1 + 8'h01 : 8'h00;
        run2 <= i_tr2 ? run2 + 8'h01 : 8'h00;
        tr1_q <= i_tr1;
        tr2_q <= i_tr2;
        aux_q <= i_aux_b;
        ph_q <= i_phase1;
    end
endmodule : slt_sensor_model

// [test/tb.sv]
// Purpose: Self-checking bench for the line sequencer, driven over APB.
// Assumes: Zero-wait APB; eight clocks a pixel; a short 16-pixel line.
// Notes: Tallies span whole lines, so where a window starts does not matter.
`timescale 1ns/1ps
`include "slt_params.svh"
module tb;
    logic clk = 1'h0; // Master clock.
    logic rst_n = 1'h0; // Reset, active low.
    logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, clr = 1'h0; // Bus and tally controls.
    logic [7:0] pa = 8'h00; // Bus address.
    logic [31:0] pwd = 32'h0, prd, rd; // Write data, read data, last read.
    logic rdy, err, perr, lr, lg, lb, rsp, axa, axb, tr1, tr2, ph1, clp, srf, ssg, iref, scan;
    logic [1:0] mux, coef; // Channel and coefficient selects.
    int num_errors = 0; // Mismatches.
    int compares = 0; // Comparisons.
    int n; // Bounded wait counter.

    // Master clock, 50 ns period.
    always #25 clk = ~clk;

    slt_seq dut_u (.i_mclk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .o_lamp_r(lr), .o_lamp_g(lg), .o_lamp_b(lb),
        .o_sensor_reset_pulse(rsp), .o_aux_pixel_pulse_a(axa), .o_aux_pixel_pulse_b(axb),
        .o_transfer_pulse_first(tr1), .o_transfer_pulse_second(tr2), .o_phase1(ph1),
        .o_clamp(clp), .o_sample_ref(srf), .o_sample_sig(ssg), .o_int_ref(iref),
        .o_mux_sel(mux), .o_coef_sel(coef), .o_scanning(scan));
    slt_sensor_model sensor_u (.i_mclk(clk), .i_clr(clr), .i_lamp({lb, lg, lr}),
        .i_tr1(tr1), .i_tr2(tr2), .i_aux_b(axb), .i_phase1(ph1), .i_mux(mux), .i_coef(coef),
        .i_rs(rsp), .i_clamp(clp), .i_ssig(ssg), .i_sref(srf));

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Counts one comparison and reports a mismatch.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'h1 && n < 16);
        if (n >= 16) begin
            num_errors++;
            $display("[ERR] %0t bus hang", $time);
            summarize();
        end
        rd = prd;
        perr = err;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask : rdc

    // Lets a mode change settle for 300 clocks, over two lines, then tallies exactly w clocks.
    task automatic meas(input int w);
        repeat (300) @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        repeat (w) @(posedge clk);
        #1;
    endtask : meas

    // Compares three neighbouring tallies.
    task automatic tc3(input int i, input logic [31:0] a, b, c);
        check(sensor_u.cnt[i], a);
        check(sensor_u.cnt[i + 1], b);
        check(sensor_u.cnt[i + 2], c);
    endtask : tc3

    // Control word with double sampling on and blue as gray channel.
    function automatic logic [31:0] cw(input logic [1:0] ill, afe, trm);
        return 32'h0000_0810 | 32'(ill) | (32'(trm) << `SLT_C_TRM) | (32'(afe) << `SLT_C_AFE);
    endfunction : cw

    // Main sequence; a line is 128 clocks, so 4096 clocks hold 32 lines.
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rdc(`SLT_A_CTRL, `SLT_RST_CTRL);
        rdc(`SLT_A_LINE, `SLT_RST_LINE);
        rdc(`SLT_A_XFER, `SLT_RST_XFER);
        rdc(`SLT_A_PIX, `SLT_RST_PIX);
        apb(1'h0, 8'h28, 32'h0);
        check({31'h0, perr}, 32'h1);
        wr(`SLT_A_LINE, 32'h0004_000F);
        wr(`SLT_A_PWM, 32'h0000_0400);
        wr(`SLT_A_LAMP_R, 32'h0005_0002);
        wr(`SLT_A_LAMP_G, 32'hFFFF_0001);
        wr(`SLT_A_LAMP_B, 32'h0003_FFFF);
        meas(4096);
        tc3(0, 32'h0, 32'h0, 32'h0);
        wr(`SLT_A_CTRL, cw(2'h3, 2'h0, 2'h0));
        meas(4096);
        tc3(0, 32'h0300, 32'h1000, 32'h0);
        tc3(7, 32'h0600, 32'h0500, 32'h0500);
        tc3(12, 32'h4, 32'h4, 32'h0);
        check(sensor_u.cnt[3], 32'h0020);
        check({31'h0, iref}, 32'h0);
        tc3(17, 32'h0400, 32'h0200, 32'h0200);
        check(sensor_u.cnt[16], 32'h01E0);
        wr(`SLT_A_CTRL, cw(2'h1, 2'h2, 2'h0));
        meas(4096);
        tc3(0, 32'h0300, 32'h0400, 32'h0);
        check(sensor_u.cnt[10], 32'h1000);
        for (int i = 0; i < 3; i++) begin
            wr(`SLT_A_LAMP_R + 8'(4 * i), 32'h0005_0002);
        end
        wr(`SLT_A_LRATE, 32'h0000_00A1);
        wr(`SLT_A_CTRL, cw(2'h2, 2'h1, 2'h0));
        meas(12288);
        tc3(0, 32'h0300, 32'h0300, 32'h0300);
        tc3(7, 32'h1000, 32'h1000, 32'h1000);
        tc3(3, 32'h0030, 32'h0060, 32'h0020);
        tc3(11, 32'h0, 32'h4, 32'h4);
        check(sensor_u.cnt[14] + sensor_u.cnt[15], 32'h0);
        wr(`SLT_A_CTRL, cw(2'h0, 2'h3, 2'h0));
        meas(12288);
        tc3(0, 32'h0300, 32'h0300, 32'h0300);
        tc3(9, 32'h3000, 32'h1000, 32'h0);
        for (int b = `SLT_C_SRST; b <= `SLT_C_STBY; b++) begin
            wr(`SLT_A_CTRL, 32'h0000_0010 | (32'h1 << b));
            meas(512);
            check(sensor_u.cnt[6], 32'h0);
        end
        wr(`SLT_A_CTRL, 32'h0000_0010);
        meas(512);
        check(sensor_u.cnt[6], 32'h0040);
        wr(`SLT_A_XFER, 32'h0000_0203);
        for (int t = 1; t < 3; t++) begin
            wr(`SLT_A_CTRL, cw(2'h0, 2'h0, 2'(t)));
            meas(1024);
            check(sensor_u.cnt[12], 32'h8);
        end
        wr(`SLT_A_CTRL, cw(2'h0, 2'h0, 2'h0) | 32'h0000_0020);
        meas(1024);
        check(sensor_u.cnt[12], 32'h4);
        check(sensor_u.cnt[13], 32'h3);
        check(sensor_u.cnt[16], 32'h0128);
        wr(`SLT_A_PIX, 32'h1000_0001);
        rdc(`SLT_A_PIX, 32'h1000_0001);
        wr(`SLT_A_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        check({31'h0, iref}, 32'h1);
        wr(`SLT_A_CTRL, 32'h0000_1010);
        n = 0;
        while (scan !== 1'h1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, scan}, 32'h1);
        wr(`SLT_A_CTRL, 32'h0000_2010);
        #1;
        check({31'h0, scan}, 32'h0);
        summarize();
    end
endmodule : tb
